// ---- shared/failsafe_pkg.sv ----
// Package with constants and carrier types for the communication-loss fail-safe writer.
// Function
// RULE_01 - The timeout setting is a 32-bit unsigned count that network silence is compared against.
// RULE_02 - After reset the timeout setting holds the equivalent of ten seconds.
// RULE_03 - Expiry raises timeout processing only when the active protocol enables timeout processing.
// RULE_04 - The fail-safe table holds at most ten entries, each a function code identifier and a value.
// RULE_05 - A triggered timeout steps through every table index and evaluates each entry.
// RULE_06 - An entry with an empty function code identifier is disabled and gets no write.
// RULE_07 - Each entry with a function code identifier has its value written to that drive function code.
// RULE_08 - After reset every entry is disabled with an empty identifier.
// RULE_09 - Each valid message restarts the silence timer, and processing runs once per loss episode.
// RULE_10 - Writes go out in ascending index order, one at a time, each awaiting completion.
package failsafe_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned DEF_TIMEOUT_MS = 10000;
  localparam logic [31:0] DEF_TIMEOUT_MS_32 = 32'h0000_2710;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam logic [15:0] CYC_PER_MS_16 = 16'(CYC_PER_MS);

  // ****************************************************************
  // Table layout and register map
  // ****************************************************************
  localparam int unsigned NUM_ENTRIES = 10;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned FC_W = 16;
  localparam int unsigned VAL_W = 16;
  localparam logic [FC_W-1:0] FC_EMPTY = 16'h0000;
  localparam logic [VAL_W-1:0] VAL_RST = 16'h0000;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADR_TIMEOUT = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_TABLE = 8'h40;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned TBL_FC_LSB = 16;
  localparam int unsigned ST_LOST_BIT = 0;
  localparam int unsigned ST_BUSY_BIT = 1;
  localparam int unsigned ST_CNT_LSB = 8;

  // Write request toward the drive's function-code store.
  typedef struct packed {
    logic req;
    logic [FC_W-1:0] code;
    logic [VAL_W-1:0] value;
  } fc_wr_s;

  // Register port read answer.
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } rd_rsp_s;

  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_WAIT, ST_HOLD} proc_e;
endpackage

// ---- hdl/silence_timer.sv ----
// Millisecond silence timer that flags expiry of the communication timeout.
`timescale 1ns/100ps
module silence_timer (
  input wire logic mclk,
  input wire logic rst_sync_n,
  input wire logic msg_valid,
  input wire logic [31:0] timeout_ms,
  output logic expired
);
  import failsafe_pkg::*;

  typedef struct packed {
    logic [15:0] pre;
    logic [31:0] ms;
    logic exp;
  } tmr_s;

  tmr_s cur_ff;
  tmr_s nxt_cur;

  assign expired = cur_ff.exp;

  // A message clears everything; a zero setting never expires so the feature can be parked.
  always_comb begin
    nxt_cur = cur_ff;
    if (msg_valid) begin
      nxt_cur = '0; // RULE_09
    end else if (!cur_ff.exp && timeout_ms != 32'h0000_0000) begin
      if (cur_ff.pre == CYC_PER_MS_16 - 16'h0001) begin
        nxt_cur.pre = '0;
        nxt_cur.ms = cur_ff.ms + 32'h0000_0001;
        if (cur_ff.ms + 32'h0000_0001 >= timeout_ms) begin
          nxt_cur.exp = 1'b1; // RULE_01
        end
      end else begin
        nxt_cur.pre = cur_ff.pre + 16'h0001;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end
endmodule

// ---- hdl/comm_loss_failsafe_writer.sv ----
// Communication-loss supervisor that writes fail-safe values to the drive's function codes.
`timescale 1ns/100ps
module comm_loss_failsafe_writer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic msg_valid,
  input wire logic proto_timeout_en,
  input wire logic [failsafe_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output failsafe_pkg::rd_rsp_s reg_rsp,
  output failsafe_pkg::fc_wr_s fc_wr,
  input wire logic fc_wr_done,
  output logic comm_lost,
  output logic failsafe_busy
);
  import failsafe_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync_ff;
  logic rst_sync_n;

  // Asynchronous assert, release through two flops so every register leaves reset on one edge.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_ff[1];

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0] timeout_ms;
    logic trig_en;
    logic [NUM_ENTRIES-1:0][FC_W-1:0] code;
    logic [NUM_ENTRIES-1:0][VAL_W-1:0] value;
    proc_e st;
    logic [IDX_W-1:0] idx;
    logic [7:0] run_cnt;
    rd_rsp_s rsp;
    fc_wr_s wr;
    logic lost;
    logic busy;
  } top_s;

  top_s cur_ff;
  top_s nxt_cur;
  logic expired;

  silence_timer u_timer (
    .mclk(mclk),
    .rst_sync_n(rst_sync_n),
    .msg_valid(msg_valid),
    .timeout_ms(cur_ff.timeout_ms),
    .expired(expired)
  );

  assign reg_rsp = cur_ff.rsp;
  assign fc_wr = cur_ff.wr;
  assign comm_lost = cur_ff.lost;
  assign failsafe_busy = cur_ff.busy;

  // Table slot decode; returns NUM_ENTRIES when the address does not hit the table.
  function automatic logic [IDX_W-1:0] tbl_slot(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - ADR_TABLE;
    if (a >= ADR_TABLE && off[1:0] == 2'b00 && off[ADDR_W-1:2] < (ADDR_W-2)'(NUM_ENTRIES)) begin
      tbl_slot = off[IDX_W+1:2];
    end else begin
      tbl_slot = IDX_W'(NUM_ENTRIES);
    end
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic [IDX_W-1:0] slot;
    slot = tbl_slot(reg_addr);
    nxt_cur = cur_ff;
    nxt_cur.rsp = '0;

    // Register writes. Table edits during a scan take effect on entries not yet visited.
    if (reg_wr) begin
      if (reg_addr == ADR_TIMEOUT) begin
        nxt_cur.timeout_ms = reg_wdata; // RULE_01
      end else if (reg_addr == ADR_CTRL) begin
        nxt_cur.trig_en = reg_wdata[CTRL_EN_BIT];
      end else if (slot != IDX_W'(NUM_ENTRIES)) begin
        nxt_cur.code[slot] = reg_wdata[TBL_FC_LSB +: FC_W]; // RULE_04
        nxt_cur.value[slot] = reg_wdata[VAL_W-1:0];
      end
    end

    // Register reads; unmapped addresses answer zero.
    if (reg_rd) begin
      nxt_cur.rsp.valid = 1'b1;
      if (reg_addr == ADR_TIMEOUT) begin
        nxt_cur.rsp.data = cur_ff.timeout_ms;
      end else if (reg_addr == ADR_CTRL) begin
        nxt_cur.rsp.data[CTRL_EN_BIT] = cur_ff.trig_en;
      end else if (reg_addr == ADR_STATUS) begin
        nxt_cur.rsp.data[ST_LOST_BIT] = cur_ff.lost;
        nxt_cur.rsp.data[ST_BUSY_BIT] = cur_ff.busy;
        nxt_cur.rsp.data[ST_CNT_LSB +: 8] = cur_ff.run_cnt;
      end else if (slot != IDX_W'(NUM_ENTRIES)) begin
        nxt_cur.rsp.data = {cur_ff.code[slot], cur_ff.value[slot]};
      end
    end

    nxt_cur.lost = expired;

    // Fail-safe sequencer.
    unique case (cur_ff.st)
      ST_IDLE: begin
        // Expiry only starts processing when the protocol and software both enable it.
        if (expired && proto_timeout_en && cur_ff.trig_en) begin // RULE_03
          nxt_cur.st = ST_SCAN;
          nxt_cur.idx = '0;
          nxt_cur.busy = 1'b1;
          nxt_cur.run_cnt = cur_ff.run_cnt + 8'h01;
        end
      end
      ST_SCAN: begin
        if (cur_ff.idx == IDX_W'(NUM_ENTRIES)) begin // RULE_05
          nxt_cur.st = ST_HOLD;
          nxt_cur.busy = 1'b0;
        end else if (cur_ff.code[cur_ff.idx] == FC_EMPTY) begin
          nxt_cur.idx = cur_ff.idx + 4'h1; // RULE_06
        end else begin
          nxt_cur.wr.req = 1'b1; // RULE_07
          nxt_cur.wr.code = cur_ff.code[cur_ff.idx];
          nxt_cur.wr.value = cur_ff.value[cur_ff.idx];
          nxt_cur.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // The request stands until the store reports completion, then the next index follows.
        if (fc_wr_done) begin // RULE_10
          nxt_cur.wr.req = 1'b0;
          nxt_cur.idx = cur_ff.idx + 4'h1;
          nxt_cur.st = ST_SCAN;
        end
      end
      ST_HOLD: begin
        // Stay here until traffic resumes, so one loss episode gives one pass.
        if (!expired) begin // RULE_09
          nxt_cur.st = ST_IDLE;
        end
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cur_ff <= '0;
      cur_ff.timeout_ms <= DEF_TIMEOUT_MS_32; // RULE_02
      cur_ff.trig_en <= 1'b1;
      cur_ff.code <= {NUM_ENTRIES{FC_EMPTY}}; // RULE_08
      cur_ff.value <= {NUM_ENTRIES{VAL_RST}};
      cur_ff.st <= ST_IDLE;
    end else begin
      cur_ff <= nxt_cur;
    end
  end
endmodule

// ---- dv/failsafe_properties.sv ----
// Concurrent checks on the ports of the communication-loss fail-safe writer.
`timescale 1ns/100ps
module failsafe_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic msg_valid,
  input wire logic proto_timeout_en,
  input wire logic [failsafe_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input failsafe_pkg::rd_rsp_s reg_rsp,
  input failsafe_pkg::fc_wr_s fc_wr,
  input wire logic fc_wr_done,
  input wire logic comm_lost,
  input wire logic failsafe_busy
);
  import failsafe_pkg::*;
  // ****************************************************************
  // Drive write handshake and pass control
  // ****************************************************************
  // The raw reset disables checks; the synchronised copy only keeps outputs low for longer.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic pass_done_ff;
  // Remembers that this loss episode already had its pass; only a clear loss flag rearms it.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pass_done_ff <= 1'b0;
    end else if (!comm_lost) begin
      pass_done_ff <= 1'b0;
    end else if ($fell(failsafe_busy)) begin
      pass_done_ff <= 1'b1;
    end
  end
  sequence s_waiting;
    fc_wr.req && !fc_wr_done;
  endsequence
  sequence s_done;
    fc_wr.req && fc_wr_done;
  endsequence
  a_req_holds: assert property (s_waiting |=> fc_wr.req && $stable(fc_wr.code) && $stable(fc_wr.value))
    else $error("write request changed before completion");
  a_req_drops: assert property (s_done |=> !fc_wr.req)
    else $error("write request held after completion");
  a_drop_after_done: assert property ($fell(fc_wr.req) |-> $past(fc_wr_done))
    else $error("write request dropped before completion");
  a_code_present: assert property (fc_wr.req |-> fc_wr.code != FC_EMPTY)
    else $error("write issued for an empty entry");
  a_write_in_pass: assert property (fc_wr.req |-> failsafe_busy)
    else $error("write issued outside a table pass");
  a_pass_on_loss: assert property ($rose(failsafe_busy) |-> comm_lost)
    else $error("table pass started without communication loss");
  a_proto_gate: assert property ($rose(failsafe_busy) |-> $past(proto_timeout_en))
    else $error("table pass started with timeout processing off");
  a_msg_clears: assert property (msg_valid |-> ##[1:3] !comm_lost)
    else $error("message did not clear the loss flag");
  a_once_episode: assert property ($rose(failsafe_busy) |-> !pass_done_ff)
    else $error("second pass within one loss episode");
endmodule
bind comm_loss_failsafe_writer failsafe_properties chk_i (.mclk(mclk), .rst_n(rst_n), .msg_valid(msg_valid),
  .proto_timeout_en(proto_timeout_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rsp(reg_rsp), .fc_wr(fc_wr), .fc_wr_done(fc_wr_done), .comm_lost(comm_lost),
  .failsafe_busy(failsafe_busy));

// ---- dv/drive_store_model.sv ----
// Behavioural function-code store of the drive that completes each write after a set latency.
`timescale 1ns/100ps
module drive_store_model (
  input wire logic mclk,
  input wire logic rst_n,
  input failsafe_pkg::fc_wr_s fc_wr,
  input wire logic [3:0] lat,
  output logic fc_wr_done
);
  import failsafe_pkg::*;
  logic [3:0] cnt_ff;
  // ****************************************************************
  // Completion
  // ****************************************************************
  // Done is a one-cycle pulse; the count restarts after it, so a request still held after done is finished again.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
      fc_wr_done <= 1'b0;
    end else begin
      fc_wr_done <= fc_wr.req && !fc_wr_done && cnt_ff == lat;
      cnt_ff <= (fc_wr.req && !fc_wr_done && cnt_ff != lat) ? cnt_ff + 4'h1 : 4'h0;
    end
  end
endmodule

// ---- dv/comm_loss_failsafe_writer_bench.sv ----
// Self-checking bench for the communication-loss fail-safe writer.
`timescale 1ns/100ps
module comm_loss_failsafe_writer_bench;
  import failsafe_pkg::*;
  logic mclk, rst_n, msg_valid, proto_timeout_en, reg_wr, reg_rd, fc_wr_done, comm_lost, failsafe_busy;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [3:0] lat;
  rd_rsp_s reg_rsp;
  fc_wr_s fc_wr;
  logic [31:0] got [$];
  logic [31:0] tbl [3] = '{32'h0005_07d0, 32'h0011_0001, 32'h0302_ffff};
  int checks, n_mismatch, n;
  comm_loss_failsafe_writer dut (.mclk(mclk), .rst_n(rst_n), .msg_valid(msg_valid),
    .proto_timeout_en(proto_timeout_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rsp(reg_rsp), .fc_wr(fc_wr), .fc_wr_done(fc_wr_done), .comm_lost(comm_lost),
    .failsafe_busy(failsafe_busy));
  drive_store_model store (.mclk(mclk), .rst_n(rst_n), .fc_wr(fc_wr), .lat(lat), .fc_wr_done(fc_wr_done));
  // ****************************************************************
  // Clock, monitor and tasks
  // ****************************************************************
  always #20 mclk = ~mclk;
  // Completed writes are logged as code and value, the same layout as a table word.
  always @(posedge mclk) begin
    if (fc_wr.req && fc_wr_done) got.push_back({fc_wr.code, fc_wr.value});
  end
  task summarize;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data are looked at in the single cycle after the strobe.
  task rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk({31'h0, reg_rsp.valid}, 32'h1);
    chk(reg_rsp.data, exp);
  endtask
  // Bounded wait for the loss flag; running out counts as a mismatch and ends the run.
  task wt(input logic want, input int lim, output int cyc);
    cyc = 0;
    while (comm_lost !== want) begin
      @(posedge mclk);
      #1;
      cyc++;
      if (cyc > lim) begin
        n_mismatch++;
        $display("[FAIL] %0t loss flag wait ran out", $time);
        summarize();
      end
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {mclk, rst_n, msg_valid, proto_timeout_en, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    lat = 4'h0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(ADR_TIMEOUT, DEF_TIMEOUT_MS_32);
    rd(ADR_CTRL, 32'h1);
    for (int i = 0; i < 10; i++) rd(ADR_TABLE + 8'(4 * i), 32'h0);
    rd(8'h30, 32'h0);
    wr(ADR_TIMEOUT, 32'h1);
    rd(ADR_TIMEOUT, 32'h1);
    // Entries at the first, a middle and the last index; the rest stay empty.
    wr(ADR_TABLE, tbl[0]);
    wr(ADR_TABLE + 8'h0c, tbl[1]);
    wr(ADR_TABLE + 8'h24, tbl[2]);
    // Episode 0 runs with timeout processing off, then a slow store, then a prompt one.
    for (int ep = 0; ep < 3; ep++) begin
      lat <= (ep == 1) ? 4'h6 : 4'h0;
      msg_valid <= 1'b1;
      @(posedge mclk);
      msg_valid <= 1'b0;
      wt(1'b0, 5, n);
      // Enables change only once the loss flag is down, so a stale expiry cannot start a pass.
      proto_timeout_en <= (ep != 0);
      wr(ADR_CTRL, 32'h1);
      wt(1'b1, 26000, n);
      chk(32'(n >= 24990), 32'h1);
      repeat (300) @(posedge mclk);
      chk(32'(got.size()), 32'(ep * 3));
      chk({31'h0, failsafe_busy}, 32'h0);
      rd(ADR_STATUS, {16'h0, 8'(ep), 8'h01});
      if (ep == 0) begin
        // With the software enable off, a protocol request during the loss must not start a pass.
        wr(ADR_CTRL, 32'h0);
        proto_timeout_en <= 1'b1;
        repeat (20) @(posedge mclk);
        chk(32'(got.size()), 32'h0);
      end
    end
    for (int i = 0; i < 6; i++) chk(got[i], tbl[i % 3]);
    msg_valid <= 1'b1;
    @(posedge mclk);
    msg_valid <= 1'b0;
    wt(1'b0, 5, n);
    chk({31'h0, comm_lost}, 32'h0);
    summarize();
  end
endmodule
